// File: hdl/sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_ADDR_OWN          16'h0980
`define SPS_ADDR_ACT          16'h0981
`define SPS_ADDR_LEN_LO       16'h0982
`define SPS_ADDR_LEN_HI       16'h0983
`define SPS_ADDR_ACT_STAT     16'h0984
`define SPS_ADDR_STAT0        16'h098E
`define SPS_ADDR_STAT1        16'h098F

`define SPS_OWN_SYNC_BIT      0
`define SPS_OWN_LATCH_INPUT_ZERO_BIT    4
`define SPS_OWN_LATCH_INPUT_ONE_BIT    5
`define SPS_OWN_MASK          8'h31

`define SPS_ACT_UNIT_BIT      0
`define SPS_ACT_OUT0_BIT      1
`define SPS_ACT_OUT1_BIT      2
`define SPS_ACT_AUTO_BIT      3
`define SPS_ACT_EXT_BIT       4
`define SPS_ACT_CHECK_BIT     5
`define SPS_ACT_WIN_BIT       6
`define SPS_ACT_DEBUG_BIT     7
`define SPS_ACT_STORE_MASK    8'h7F

`define SPS_OWN_RESET         8'h00
`define SPS_ACT_RESET         8'h00
`define SPS_LEN_RESET         16'h0000
`define SPS_CFG_LEN_WORD      16'h0002

`define SPS_CLK_PERIOD_NS     10
`define SPS_PULSE_UNIT_NS     10
`define SPS_CYC_PER_UNIT      ((`SPS_PULSE_UNIT_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)

`endif

// File: hdl/sps_pkg.sv
package sps_pkg;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sps_bus_req_t;

   typedef enum logic [1:0] {
      SPS_IDLE,
      SPS_TIMED,
      SPS_HELD
   } sps_pulse_state_t;

endpackage

// File: hdl/sps_sync_pulse_control_bank.sv
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_sync_pulse_control_bank (
   // clock and reset
   input  wire logic                 I_CLOCK,
   input  wire logic                 I_SYS_RST,
   // network-side register port
   input  wire sps_pkg::sps_bus_req_t I_NET_REQ,
   output logic [7:0]                O_NET_RDATA,
   // host-side register port
   input  wire sps_pkg::sps_bus_req_t I_HOST_REQ,
   output logic [7:0]                O_HOST_RDATA,
   // device configuration
   input  wire logic                 I_SYS_TIME_HOST_CTRL,
   input  wire logic                 I_WR_ACK_EN,
   input  wire logic                 I_CFG_LOAD,
   input  wire logic [15:0]          I_CFG_PULSE_LEN,
   // timing unit
   input  wire logic                 I_START_TIME_WR,
   input  wire logic                 I_START_LOW_ONLY,
   input  wire logic                 I_START_OUT_OF_WINDOW,
   input  wire logic                 I_CYCLE_TIME_ZERO,
   input  wire logic [1:0]           I_PULSE_REQ,
   input  wire logic [1:0]           I_LATCH_IRQ,
   // controls to the timing and latch units
   output logic                      O_OWN_SYNC_HOST,
   output logic [1:0]                O_LATCH_OWN_HOST,
   output logic                      O_UNIT_ACTIVE,
   output logic [1:0]                O_OUT_EN,
   output logic                      O_EXTEND_START,
   output logic                      O_START_IMMEDIATE,
   output logic                      O_NEAR_WIN_LONG,
   // sync outputs and events
   output logic [1:0]                O_SYNC_OUT,
   output logic [1:0]                O_APP_EVENT_REQ,
   output logic [1:0]                O_LATCH_IRQ_NET,
   output logic [1:0]                O_LATCH_IRQ_HOST
);

   logic [7:0]  own_q, own_d;
   logic [7:0]  act_q, act_d;
   logic [15:0] len_q, len_d;
   logic [1:0]  pend_q, pend_d;
   logic        chk_q, chk_d;
   logic        shot_done_q, shot_done_d;
   logic [1:0]  evt_q, evt_d;
   logic [7:0]  net_rd_q, net_rd_d;
   logic [7:0]  host_rd_q, host_rd_d;
   logic        ext_q, ext_d;
   logic        imm_q, imm_d;
   logic        dbg_q, dbg_d;
   logic [1:0]  lirq_net_q, lirq_net_d;
   logic [1:0]  lirq_host_q, lirq_host_d;
   logic [7:0]  div_q, div_d;
   logic        tick;
   logic        act_wr;
   logic [7:0]  act_wdata;
   logic        activate;
   logic [1:0]  fire;
   logic [1:0]  emitted;
   logic [1:0]  ack_clr;
   logic [1:0]  host_evt_clr;
   logic [1:0]  sync_q;

   localparam logic [7:0] CYC_PER_UNIT = 8'(`SPS_CYC_PER_UNIT);

   function automatic logic [7:0] read_reg(input logic [15:0] addr, input logic [7:0] own, input logic [7:0] act,
                                           input logic [15:0] len, input logic [1:0] pend, input logic chk);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         `SPS_ADDR_OWN:      v = own & `SPS_OWN_MASK;
         `SPS_ADDR_ACT:      v = act & `SPS_ACT_STORE_MASK;
         `SPS_ADDR_LEN_LO:   v = len[7:0];
         `SPS_ADDR_LEN_HI:   v = len[15:8];
         `SPS_ADDR_ACT_STAT: v = {5'h00, chk, pend};
         `SPS_ADDR_STAT0:    v = {7'h00, pend[0]};
         `SPS_ADDR_STAT1:    v = {7'h00, pend[1]};
         default:            v = 8'h00;
      endcase
      return v;
   endfunction

   // pulse length unit divider, one-cycle enable per 10 ns unit
   always_comb begin
      tick  = (div_q == CYC_PER_UNIT - 8'h01);
      div_d = tick ? 8'h00 : div_q + 8'h01;
   end

   // activation write is taken only from the side that owns the unit
   always_comb begin
      if (own_q[`SPS_OWN_SYNC_BIT]) begin
         act_wr    = I_HOST_REQ.wr && (I_HOST_REQ.addr == `SPS_ADDR_ACT);
         act_wdata = I_HOST_REQ.wdata;
      end else begin
         act_wr    = I_NET_REQ.wr && (I_NET_REQ.addr == `SPS_ADDR_ACT);
         act_wdata = I_NET_REQ.wdata;
      end
   end

   // control registers
   always_comb begin
      own_d = own_q;
      if (I_NET_REQ.wr && (I_NET_REQ.addr == `SPS_ADDR_OWN)) begin
         own_d = I_NET_REQ.wdata & `SPS_OWN_MASK;
      end
      if (I_SYS_TIME_HOST_CTRL) begin
         own_d[`SPS_OWN_LATCH_INPUT_ZERO_BIT] = 1'b1;
      end
      act_d = act_q;
      dbg_d = 1'b0;
      if (act_wr) begin
         act_d = act_wdata & `SPS_ACT_STORE_MASK;
         dbg_d = act_wdata[`SPS_ACT_DEBUG_BIT];
      end
      // auto-activation only from an idle unit, where the start time is writable
      if (I_START_TIME_WR && act_q[`SPS_ACT_AUTO_BIT] && !act_q[`SPS_ACT_UNIT_BIT]) begin
         act_d[`SPS_ACT_UNIT_BIT] = 1'b1;
      end
      ext_d    = I_START_TIME_WR && I_START_LOW_ONLY && act_q[`SPS_ACT_EXT_BIT];
      activate = act_d[`SPS_ACT_UNIT_BIT] && !act_q[`SPS_ACT_UNIT_BIT];
      chk_d    = chk_q;
      imm_d    = 1'b0;
      if (activate) begin
         chk_d = I_START_OUT_OF_WINDOW;
         imm_d = I_START_OUT_OF_WINDOW && act_d[`SPS_ACT_CHECK_BIT];
      end
      len_d = len_q;
      if (I_CFG_LOAD) begin
         len_d = I_CFG_PULSE_LEN;
      end
   end

   // pulse gating, single-shot, pending and event requests
   always_comb begin
      emitted[0] = I_PULSE_REQ[0] && act_q[`SPS_ACT_UNIT_BIT] && act_q[`SPS_ACT_OUT0_BIT] && !shot_done_q;
      emitted[1] = I_PULSE_REQ[1] && act_q[`SPS_ACT_UNIT_BIT] && act_q[`SPS_ACT_OUT1_BIT];
      fire[0]    = emitted[0] || (dbg_q && act_q[`SPS_ACT_OUT0_BIT]);
      fire[1]    = emitted[1] || (dbg_q && act_q[`SPS_ACT_OUT1_BIT]);
      shot_done_d = shot_done_q;
      if (emitted[0] && I_CYCLE_TIME_ZERO) begin
         shot_done_d = 1'b1;
      end
      if (activate) begin
         shot_done_d = 1'b0;
      end
      pend_d = pend_q & ~emitted;
      if (!act_d[`SPS_ACT_UNIT_BIT]) begin
         pend_d = 2'b00;
      end
      if (activate) begin
         pend_d = pend_d | {act_d[`SPS_ACT_OUT1_BIT], act_d[`SPS_ACT_OUT0_BIT]};
      end
      ack_clr[0] = (I_NET_REQ.rd && (I_NET_REQ.addr == `SPS_ADDR_STAT0))
                || (I_HOST_REQ.rd && (I_HOST_REQ.addr == `SPS_ADDR_STAT0))
                || (I_HOST_REQ.wr && I_WR_ACK_EN && (I_HOST_REQ.addr == `SPS_ADDR_STAT0));
      ack_clr[1] = (I_NET_REQ.rd && (I_NET_REQ.addr == `SPS_ADDR_STAT1))
                || (I_HOST_REQ.rd && (I_HOST_REQ.addr == `SPS_ADDR_STAT1))
                || (I_HOST_REQ.wr && I_WR_ACK_EN && (I_HOST_REQ.addr == `SPS_ADDR_STAT1));
      host_evt_clr[0] = I_WR_ACK_EN ? (I_HOST_REQ.wr && (I_HOST_REQ.addr == `SPS_ADDR_STAT0))
                                    : (I_HOST_REQ.rd && (I_HOST_REQ.addr == `SPS_ADDR_STAT0));
      host_evt_clr[1] = I_WR_ACK_EN ? (I_HOST_REQ.wr && (I_HOST_REQ.addr == `SPS_ADDR_STAT1))
                                    : (I_HOST_REQ.rd && (I_HOST_REQ.addr == `SPS_ADDR_STAT1));
      // a pulse in the clearing cycle keeps its request
      evt_d = (evt_q & ~host_evt_clr) | fire;
   end

   // latch interrupts follow the owning side
   always_comb begin
      lirq_host_d = I_LATCH_IRQ & {own_q[`SPS_OWN_LATCH_INPUT_ONE_BIT], own_q[`SPS_OWN_LATCH_INPUT_ZERO_BIT]};
      lirq_net_d  = I_LATCH_IRQ & ~{own_q[`SPS_OWN_LATCH_INPUT_ONE_BIT], own_q[`SPS_OWN_LATCH_INPUT_ZERO_BIT]};
   end

   // read data, one cycle after the strobe
   always_comb begin
      net_rd_d  = I_NET_REQ.rd ? read_reg(I_NET_REQ.addr, own_q, act_q, len_q, pend_q, chk_q) : net_rd_q;
      host_rd_d = I_HOST_REQ.rd ? read_reg(I_HOST_REQ.addr, own_q, act_q, len_q, pend_q, chk_q) : host_rd_q;
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         own_q       <= `SPS_OWN_RESET;
         act_q       <= `SPS_ACT_RESET;
         len_q       <= `SPS_LEN_RESET;
         pend_q      <= 2'b00;
         chk_q       <= 1'b0;
         shot_done_q <= 1'b0;
         evt_q       <= 2'b00;
         net_rd_q    <= 8'h00;
         host_rd_q   <= 8'h00;
         ext_q       <= 1'b0;
         imm_q       <= 1'b0;
         dbg_q       <= 1'b0;
         lirq_net_q  <= 2'b00;
         lirq_host_q <= 2'b00;
         div_q       <= 8'h00;
      end else begin
         own_q       <= own_d;
         act_q       <= act_d;
         len_q       <= len_d;
         pend_q      <= pend_d;
         chk_q       <= chk_d;
         shot_done_q <= shot_done_d;
         evt_q       <= evt_d;
         net_rd_q    <= net_rd_d;
         host_rd_q   <= host_rd_d;
         ext_q       <= ext_d;
         imm_q       <= imm_d;
         dbg_q       <= dbg_d;
         lirq_net_q  <= lirq_net_d;
         lirq_host_q <= lirq_host_d;
         div_q       <= div_d;
      end
   end

   // one pulse shaper per sync output; a retrigger while busy is dropped
   for (genvar g = 0; g < 2; g++) begin : g_shaper
      sps_pkg::sps_pulse_state_t st_q, st_d;
      logic [15:0]               cnt_q, cnt_d;
      logic                      out_q;

      always_comb begin
         st_d  = st_q;
         cnt_d = cnt_q;
         case (st_q)
            sps_pkg::SPS_IDLE: begin
               if (fire[g]) begin
                  if (len_q == 16'h0000) begin
                     st_d = sps_pkg::SPS_HELD;
                  end else begin
                     st_d  = sps_pkg::SPS_TIMED;
                     cnt_d = len_q;
                  end
               end
            end
            sps_pkg::SPS_TIMED: begin
               if (tick) begin
                  cnt_d = cnt_q - 16'h0001;
                  if (cnt_q == 16'h0001) begin
                     st_d = sps_pkg::SPS_IDLE;
                  end
               end
            end
            sps_pkg::SPS_HELD: begin
               if (ack_clr[g]) begin
                  st_d = sps_pkg::SPS_IDLE;
               end
            end
            default: begin
               st_d = sps_pkg::SPS_IDLE;
            end
         endcase
      end

      always_ff @(posedge I_CLOCK) begin
         if (I_SYS_RST) begin
            st_q   <= sps_pkg::SPS_IDLE;
            cnt_q  <= 16'h0000;
            out_q  <= 1'b0;
         end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            out_q  <= (st_d != sps_pkg::SPS_IDLE);
         end
      end

      // one flop per output, so each bit of the bus has a single driver
      assign sync_q[g] = out_q;
   end

   assign O_NET_RDATA       = net_rd_q;
   assign O_HOST_RDATA      = host_rd_q;
   assign O_OWN_SYNC_HOST   = own_q[`SPS_OWN_SYNC_BIT];
   assign O_LATCH_OWN_HOST  = {own_q[`SPS_OWN_LATCH_INPUT_ONE_BIT], own_q[`SPS_OWN_LATCH_INPUT_ZERO_BIT]};
   assign O_UNIT_ACTIVE     = act_q[`SPS_ACT_UNIT_BIT];
   assign O_OUT_EN          = {act_q[`SPS_ACT_OUT1_BIT], act_q[`SPS_ACT_OUT0_BIT]};
   assign O_EXTEND_START    = ext_q;
   assign O_START_IMMEDIATE = imm_q;
   assign O_NEAR_WIN_LONG   = act_q[`SPS_ACT_WIN_BIT];
   assign O_SYNC_OUT        = sync_q;
   assign O_APP_EVENT_REQ   = evt_q;
   assign O_LATCH_IRQ_NET   = lirq_net_q;
   assign O_LATCH_IRQ_HOST  = lirq_host_q;

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);

   sequence s_ack_mode_fire;
      (len_q == 16'h0000) && fire[0] && (g_shaper[0].st_q == sps_pkg::SPS_IDLE);
   endsequence

   a_owner_write_only: assert property (
      (I_NET_REQ.wr && I_NET_REQ.addr == `SPS_ADDR_ACT && own_q[0] && !I_START_TIME_WR && !I_HOST_REQ.wr)
      |=> (act_q == $past(act_q)))
      else $error("activation changed by a non-owning side");
   a_latch_input_zero_forced: assert property (
      I_SYS_TIME_HOST_CTRL |=> O_LATCH_OWN_HOST[0])
      else $error("latch zero not forced to host side");
   a_auto_activate: assert property (
      (I_START_TIME_WR && act_q[3] && !act_q[0]) |=> O_UNIT_ACTIVE)
      else $error("auto-activation missed");
   a_debug_reads_zero: assert property (
      I_NET_REQ.rd && I_NET_REQ.addr == `SPS_ADDR_ACT |=> !O_NET_RDATA[7])
      else $error("debug bit read back as one");
   a_ack_mode_hold: assert property (
      s_ack_mode_fire ##1 (!ack_clr[0])[*3] |=> O_SYNC_OUT[0])
      else $error("acknowledge-mode output dropped before status read");
   a_timed_length: assert property (
      (len_q == 16'h0003 && fire[0] && g_shaper[0].st_q == sps_pkg::SPS_IDLE && !I_CFG_LOAD)
      |=> O_SYNC_OUT[0] [*3] ##1 !O_SYNC_OUT[0])
      else $error("timed pulse length wrong");
   a_pending_set: assert property (
      (activate && act_d[1]) |=> (pend_q[0] || $past(emitted[0])))
      else $error("pending not set on activation");
   a_event_read_clear: assert property (
      (!I_WR_ACK_EN && I_HOST_REQ.rd && I_HOST_REQ.addr == `SPS_ADDR_STAT0 && !fire[0]) |=> !O_APP_EVENT_REQ[0])
      else $error("host read did not clear event request");
   a_event_set_wins: assert property (
      fire[0] |=> O_APP_EVENT_REQ[0])
      else $error("event request lost");
   // a request arriving a few cycles after the single shot, with no re-activation between, is refused
   a_single_shot: assert property (
      (emitted[0] && I_CYCLE_TIME_ZERO && !activate) ##1 (!activate)[*4] ##1 (I_PULSE_REQ[0] && !activate)
      |-> !emitted[0])
      else $error("second pulse in single-shot mode");

   sequence s_debug_write;
      act_wr && act_wdata[`SPS_ACT_DEBUG_BIT];
   endsequence

   a_host_own_refused: assert property (
      (I_HOST_REQ.wr && I_HOST_REQ.addr == `SPS_ADDR_OWN && !I_NET_REQ.wr && !I_SYS_TIME_HOST_CTRL)
      |=> (own_q == $past(own_q)))
      else $error("host write changed the ownership register");
   a_latch_host_route: assert property (
      1'b1 |=> (O_LATCH_IRQ_HOST == ($past(I_LATCH_IRQ) & $past(O_LATCH_OWN_HOST))))
      else $error("latch interrupt not routed to host side");
   a_latch_net_route: assert property (
      1'b1 |=> (O_LATCH_IRQ_NET == ($past(I_LATCH_IRQ) & ~$past(O_LATCH_OWN_HOST))))
      else $error("latch interrupt not routed to network side");
   a_extend_pulse: assert property (
      (I_START_TIME_WR && I_START_LOW_ONLY && act_q[`SPS_ACT_EXT_BIT]) |=> O_EXTEND_START)
      else $error("start time extension not requested");
   a_no_extend: assert property (
      !act_q[`SPS_ACT_EXT_BIT] |=> !O_EXTEND_START)
      else $error("start time extended with extension off");
   a_check_off_waits: assert property (
      !act_d[`SPS_ACT_CHECK_BIT] |=> !O_START_IMMEDIATE)
      else $error("immediate start with plausibility check off");
   a_immediate_start: assert property (
      (activate && I_START_OUT_OF_WINDOW && act_d[`SPS_ACT_CHECK_BIT]) |=> O_START_IMMEDIATE)
      else $error("immediate start missed");
   a_window_select: assert property (
      act_wr |=> (O_NEAR_WIN_LONG == $past(act_wdata[`SPS_ACT_WIN_BIT])))
      else $error("near-future window not taken from write");
   a_debug_fires: assert property (
      s_debug_write |=> ((fire & O_OUT_EN) == O_OUT_EN))
      else $error("debug pulse missing on an enabled output");
   a_debug_clears: assert property (
      s_debug_write ##1 !act_wr |=> !dbg_q)
      else $error("debug request did not clear itself");
   a_out0_gated: assert property (
      !act_q[`SPS_ACT_OUT0_BIT] |-> !fire[0])
      else $error("first output fired while disabled");
   a_out1_gated: assert property (
      !act_q[`SPS_ACT_OUT1_BIT] |-> !fire[1])
      else $error("second output fired while disabled");
   a_unit_off_quiet: assert property (
      !act_q[`SPS_ACT_UNIT_BIT] |-> (emitted == 2'b00))
      else $error("pulse taken while the unit is off");
   a_length_load: assert property (
      I_CFG_LOAD |=> (len_q == $past(I_CFG_PULSE_LEN)))
      else $error("pulse length not loaded from configuration");
   a_length_read_only: assert property (
      !I_CFG_LOAD |=> (len_q == $past(len_q)))
      else $error("pulse length changed without a configuration load");
   a_pending_off: assert property (
      !O_UNIT_ACTIVE |-> (pend_q == 2'b00))
      else $error("pending shown while the unit is off");
   a_first_pulse_clears: assert property (
      emitted[1] |=> !pend_q[1])
      else $error("second output pending after its first pulse");
   a_check_result: assert property (
      activate |=> (chk_q == $past(I_START_OUT_OF_WINDOW)))
      else $error("plausibility result not stored at activation");
   a_event1_ack_write: assert property (
      (I_WR_ACK_EN && I_HOST_REQ.wr && I_HOST_REQ.addr == `SPS_ADDR_STAT1 && !fire[1])
      |=> !O_APP_EVENT_REQ[1])
      else $error("host acknowledge write did not clear event request");
   a_event1_read_clear: assert property (
      (!I_WR_ACK_EN && I_HOST_REQ.rd && I_HOST_REQ.addr == `SPS_ADDR_STAT1 && !fire[1])
      |=> !O_APP_EVENT_REQ[1])
      else $error("host read did not clear second event request");
   a_event0_read_keeps: assert property (
      (I_WR_ACK_EN && O_APP_EVENT_REQ[0] && !(I_HOST_REQ.wr && I_HOST_REQ.addr == `SPS_ADDR_STAT0))
      |=> O_APP_EVENT_REQ[0])
      else $error("event request cleared without acknowledge write");

endmodule // sps_sync_pulse_control_bank

// File: bench/sps_host_model.sv
`timescale 1ns/1ps

module sps_host_model (
   // clock
   input  wire logic             i_clk,
   // host register port
   output sps_pkg::sps_bus_req_t o_req,
   input  wire logic [7:0]       i_rdata
);
   initial o_req = '0;

   // released lines show the inverse of the last value, so a design that
   // samples outside the strobe sees garbage rather than a lucky match
   task automatic idle();
      o_req.wr    = 1'b0;
      o_req.rd    = 1'b0;
      o_req.addr  = ~o_req.addr;
      o_req.wdata = ~o_req.wdata;
   endtask

   // entered at a falling edge; strobe held over exactly one rising edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_clk);
      idle();
      @(negedge i_clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~o_req.wdata};
      @(negedge i_clk);
      idle();
      @(negedge i_clk);
      d = i_rdata;
   endtask
endmodule // sps_host_model

// File: bench/sps_sync_pulse_control_bank_tb_top.sv
`timescale 1ns/1ps

module sps_sync_pulse_control_bank_tb_top;
   logic                  clk, rst, st_host, wr_ack, cfg_ld, st_wr, st_low, st_oow, cyc_zero;
   logic                  own_host, unit_act, ext_st, st_imm, win_long;
   logic [1:0]            pulse_req, latch_irq, latch_own, out_en, sync_out, evt, irq_net, irq_host;
   logic [15:0]           cfg_len;
   logic [7:0]            net_rdata, host_rdata, rv;
   sps_pkg::sps_bus_req_t net_req, host_req;
   int                    n_errors, checks, hi;

   initial clk = 1'b0;
   always #5 clk = ~clk;

   sps_sync_pulse_control_bank u_dut (
      .I_CLOCK(clk), .I_SYS_RST(rst), .I_NET_REQ(net_req), .O_NET_RDATA(net_rdata),
      .I_HOST_REQ(host_req), .O_HOST_RDATA(host_rdata), .I_SYS_TIME_HOST_CTRL(st_host),
      .I_WR_ACK_EN(wr_ack), .I_CFG_LOAD(cfg_ld), .I_CFG_PULSE_LEN(cfg_len),
      .I_START_TIME_WR(st_wr), .I_START_LOW_ONLY(st_low), .I_START_OUT_OF_WINDOW(st_oow),
      .I_CYCLE_TIME_ZERO(cyc_zero), .I_PULSE_REQ(pulse_req), .I_LATCH_IRQ(latch_irq),
      .O_OWN_SYNC_HOST(own_host), .O_LATCH_OWN_HOST(latch_own), .O_UNIT_ACTIVE(unit_act),
      .O_OUT_EN(out_en), .O_EXTEND_START(ext_st), .O_START_IMMEDIATE(st_imm),
      .O_NEAR_WIN_LONG(win_long), .O_SYNC_OUT(sync_out), .O_APP_EVENT_REQ(evt),
      .O_LATCH_IRQ_NET(irq_net), .O_LATCH_IRQ_HOST(irq_host)
   );

   sps_host_model u_host (.i_clk(clk), .o_req(host_req), .i_rdata(host_rdata));

   task automatic give_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic net_wr(input logic [15:0] a, input logic [7:0] d);
      net_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc(1);
      net_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      cyc(1);
   endtask

   // read data stands until the next read, so sampling two edges on is safe
   task automatic nrd_chk(input logic [15:0] a, input logic [7:0] e);
      net_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
      cyc(1);
      net_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
      cyc(1);
      check($sformatf("rd %h", a), {8'h00, net_rdata}, {8'h00, e});
   endtask

   task automatic load_len(input logic [15:0] v);
      cfg_len = v;
      cfg_ld = 1'b1;
      cyc(1);
      cfg_ld = 1'b0;
      cfg_len = ~v;
      cyc(1);
   endtask

   task automatic pulse_count(input logic [1:0] m, input int b, input int n, output int c);
      pulse_req = m;
      c = 0;
      repeat (n) begin
         cyc(1);
         pulse_req = 2'b00;
         if (sync_out[b] === 1'b1) c++;
      end
   endtask

   task automatic s_reset();
      logic [15:0] a [8] = '{16'h0980, 16'h0981, 16'h0982, 16'h0983, 16'h0984, 16'h098E, 16'h098F, 16'h0985};
      foreach (a[i]) nrd_chk(a[i], 8'h00);
      check("sync out", sync_out, 2'b00);
   endtask

   task automatic s_own();
      net_wr(16'h0980, 8'hFF);
      nrd_chk(16'h0980, 8'h31);
      check("own sync", own_host, 1'b1);
      check("latch own", latch_own, 2'b11);
      u_host.wr(16'h0980, 8'h00);
      nrd_chk(16'h0980, 8'h31);
      latch_irq = 2'b10;
      cyc(3);
      check("irq host", irq_host, 2'b10);
      check("irq net", irq_net, 2'b00);
      net_wr(16'h0980, 8'h01);
      cyc(2);
      check("irq net", irq_net, 2'b10);
      st_host = 1'b1;
      latch_irq = 2'b01;
      cyc(3);
      nrd_chk(16'h0980, 8'h11);
      check("irq host", irq_host, 2'b01);
      st_host = 1'b0;
      latch_irq = 2'b00;
   endtask

   task automatic s_act();
      net_wr(16'h0981, 8'h07);
      check("unit active", unit_act, 1'b0);
      u_host.wr(16'h0981, 8'h07);
      check("unit active", unit_act, 1'b1);
      check("out enable", out_en, 2'b11);
      nrd_chk(16'h0984, 8'h03);
      nrd_chk(16'h098E, 8'h01);
      nrd_chk(16'h098F, 8'h01);
   endtask

   task automatic s_pulse();
      load_len(16'h0003);
      net_wr(16'h0982, 8'hFF);
      nrd_chk(16'h0982, 8'h03);
      nrd_chk(16'h0983, 8'h00);
      pulse_count(2'b01, 0, 8, hi);
      check("pulse cycles", 16'(hi), 16'h0003);
      check("event req", evt, 2'b01);
      nrd_chk(16'h0984, 8'h02);
      u_host.rd(16'h098E, rv);
      check("status0", rv, 8'h00);
      cyc(1);
      check("event req", evt, 2'b00);
      wr_ack = 1'b1;
      pulse_count(2'b01, 0, 5, hi);
      check("pulse cycles", 16'(hi), 16'h0003);
      u_host.rd(16'h098E, rv);
      check("status0", rv, 8'h00);
      check("event req", evt, 2'b01);
      u_host.wr(16'h098E, 8'h00);
      check("event req", evt, 2'b00);
      wr_ack = 1'b0;
   endtask

   task automatic s_ack();
      load_len(16'h0000);
      pulse_count(2'b10, 1, 8, hi);
      check("held cycles", 16'(hi), 16'h0008);
      check("held pulse", sync_out, 2'b10);
      check("event req", evt, 2'b10);
      u_host.rd(16'h098F, rv);
      check("status1", rv, 8'h00);
      cyc(1);
      check("released", sync_out, 2'b00);
      check("event req", evt, 2'b00);
      wr_ack = 1'b1;
      pulse_count(2'b10, 1, 4, hi);
      check("held cycles", 16'(hi), 16'h0004);
      u_host.wr(16'h098F, 8'h00);
      check("event req", evt, 2'b00);
      check("released", sync_out, 2'b00);
      wr_ack = 1'b0;
   endtask

   task automatic s_debug();
      u_host.wr(16'h0981, 8'h85);
      cyc(2);
      check("debug pulse", sync_out, 2'b10);
      nrd_chk(16'h0981, 8'h05);
      u_host.rd(16'h098F, rv);
      cyc(1);
      check("released", sync_out, 2'b00);
   endtask

   task automatic s_single();
      load_len(16'h0002);
      cyc_zero = 1'b1;
      u_host.wr(16'h0981, 8'h00);
      nrd_chk(16'h0984, 8'h00);
      u_host.wr(16'h0981, 8'h03);
      pulse_count(2'b01, 0, 5, hi);
      check("shot cycles", 16'(hi), 16'h0002);
      pulse_count(2'b01, 0, 5, hi);
      check("second shot", 16'(hi), 16'h0000);
      cyc_zero = 1'b0;
   endtask

   task automatic s_start();
      logic saw_ext, saw_imm;
      u_host.wr(16'h0981, 8'h00);
      check("unit active", unit_act, 1'b0);
      u_host.wr(16'h0981, 8'h78);
      nrd_chk(16'h0981, 8'h78);
      check("window", win_long, 1'b1);
      st_oow = 1'b1;
      st_low = 1'b1;
      st_wr = 1'b1;
      saw_ext = 1'b0;
      saw_imm = 1'b0;
      repeat (5) begin
         cyc(1);
         st_wr = 1'b0;
         if (ext_st === 1'b1) saw_ext = 1'b1;
         if (st_imm === 1'b1) saw_imm = 1'b1;
      end
      check("extend", saw_ext, 1'b1);
      check("immediate", saw_imm, 1'b1);
      check("unit active", unit_act, 1'b1);
      nrd_chk(16'h0984, 8'h04);
   endtask

   initial begin
      {rst, st_host, wr_ack, cfg_ld, st_wr, st_low, st_oow, cyc_zero} = 8'hFF;
      {st_host, wr_ack, cfg_ld, st_wr, st_low, st_oow, cyc_zero} = '0;
      pulse_req = 2'b00;
      latch_irq = 2'b00;
      cfg_len = 16'h0000;
      net_req = '0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      s_reset();
      s_own();
      s_act();
      s_pulse();
      s_ack();
      s_debug();
      s_single();
      s_start();
      give_verdict();
   end

   // the whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule // sps_sync_pulse_control_bank_tb_top
